/* File: include/rdt_pkg.sv */
// shared constants and types of the residual differential trip logic
package rdt_pkg;

	// ==========================================
	// widths
	localparam int CW = 20;
	localparam int SW = 22;
	localparam int GW = 16;
	localparam int TW = 40;
	localparam int NGRP = 8;
	localparam int NFLD = 5;

	// ==========================================
	// register map
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_DIFF   = 12'h008;
	localparam logic [11:0] ADDR_BIAS   = 12'h00C;
	localparam logic [11:0] ADDR_BLKCNT = 12'h010;
	localparam logic [11:0] ADDR_GRP    = 12'h100;
	localparam logic [11:0] ADDR_GRPEND = 12'h200;

	// ==========================================
	// setting group fields
	localparam int F_PICK = 0;
	localparam int F_TP1  = 1;
	localparam int F_TP2  = 2;
	localparam int F_SL1  = 3;
	localparam int F_SL2  = 4;

	// ==========================================
	// control bits
	localparam int CB_INSEL = 0;
	localparam int CB_DIR   = 1;
	localparam int CB_BIAS  = 2;
	localparam int CB_CED   = 3;
	localparam int CB_FORCE = 4;
	localparam int CB_TBLK  = 5;
	localparam int CB_COMP  = 6;
	localparam logic [5:0] RST_CTRL = 6'h00;

	// ==========================================
	// reset values, pick-up and slopes in 0.01 %, turn points in 0.01 In
	localparam logic [GW-1:0] RST_PICK = 16'h03E8;
	localparam logic [GW-1:0] RST_TP1  = 16'h0064;
	localparam logic [GW-1:0] RST_TP2  = 16'h012C;
	localparam logic [GW-1:0] RST_SL1  = 16'h03E8;
	localparam logic [GW-1:0] RST_SL2  = 16'h0FA0;

	// ==========================================
	// scaling: currents carried in units of 0.0001 In
	localparam logic [SW-1:0] TP_SCALE  = 22'h000064;
	localparam logic [TW-1:0] PCT_SCALE = 40'h0000002710;

	typedef enum logic [1:0] {CondNormal, CondTrip, CondBlocked} rdt_cond_t;

endpackage : rdt_pkg

/* File: verilog/rdt_mag.sv */
// phasor magnitude estimate, max plus three eighths of min
`timescale 1ns/1ps
module rdt_mag (
	input  wire logic signed [rdt_pkg::SW-1:0] re,
	input  wire logic signed [rdt_pkg::SW-1:0] im,
	output logic        [rdt_pkg::SW-1:0] mag
);
	logic [rdt_pkg::SW-1:0] absRe;
	logic [rdt_pkg::SW-1:0] absIm;
	logic [rdt_pkg::SW-1:0] hi;
	logic [rdt_pkg::SW-1:0] lo;

	// ==========================================
	// estimate, error under 7 %, no multiplier needed
	always_comb
	begin
		absRe = re[rdt_pkg::SW-1] ? rdt_pkg::SW'(-re) : rdt_pkg::SW'(re);
		absIm = im[rdt_pkg::SW-1] ? rdt_pkg::SW'(-im) : rdt_pkg::SW'(im);
		hi    = (absRe > absIm) ? absRe : absIm;
		lo    = (absRe > absIm) ? absIm : absRe;
		mag   = hi + (lo >> 2) + (lo >> 3);
	end
endmodule : rdt_mag

/* File: verilog/rdt_curve.sv */
// two slope bias characteristic, threshold scaled by ten thousand
`timescale 1ns/1ps
module rdt_curve (
	input  wire logic [rdt_pkg::SW-1:0] bias,
	input  wire logic [rdt_pkg::GW-1:0] pick,
	input  wire logic [rdt_pkg::GW-1:0] tp1,
	input  wire logic [rdt_pkg::GW-1:0] tp2,
	input  wire logic [rdt_pkg::GW-1:0] sl1,
	input  wire logic [rdt_pkg::GW-1:0] sl2,
	output logic      [rdt_pkg::TW-1:0] thr
);
	logic [rdt_pkg::SW-1:0] tp1c;
	logic [rdt_pkg::SW-1:0] tp2c;
	logic [rdt_pkg::SW-1:0] span1;
	logic [rdt_pkg::SW-1:0] span2;

	// ==========================================
	// segment spans
	always_comb
	begin
		tp1c  = rdt_pkg::SW'(tp1) * rdt_pkg::TP_SCALE;
		tp2c  = rdt_pkg::SW'(tp2) * rdt_pkg::TP_SCALE;
		span1 = '0;
		span2 = '0;
		if (bias > tp1c)
			span1 = ((bias < tp2c) ? bias : tp2c) - tp1c;
		// second slope only past the second turn point
		if (bias > tp2c && tp2c > tp1c)
			span2 = bias - tp2c;
		if (tp2c <= tp1c)
			span1 = (bias > tp1c) ? bias - tp1c : '0;
		thr = rdt_pkg::TW'(pick) * rdt_pkg::PCT_SCALE
			+ rdt_pkg::TW'(sl1) * rdt_pkg::TW'(span1)
			+ rdt_pkg::TW'(sl2) * rdt_pkg::TW'(span2);
	end
endmodule : rdt_curve

/* File: verilog/rdt_trip.sv */
// residual differential comparator with blocking and APB settings
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
module rdt_trip (
	input  wire logic                      clk,
	input  wire logic                      nrst,
	input  wire logic                      ce,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [11:0]               paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      sampleValid,
	input  wire logic signed [rdt_pkg::CW-1:0] phaseOneCurrentRe,
	input  wire logic signed [rdt_pkg::CW-1:0] phaseOneCurrentIm,
	input  wire logic signed [rdt_pkg::CW-1:0] phaseTwoCurrentRe,
	input  wire logic signed [rdt_pkg::CW-1:0] phaseTwoCurrentIm,
	input  wire logic signed [rdt_pkg::CW-1:0] phaseThreeCurrentRe,
	input  wire logic signed [rdt_pkg::CW-1:0] phaseThreeCurrentIm,
	input  wire logic signed [rdt_pkg::CW-1:0] residualInputOneRe,
	input  wire logic signed [rdt_pkg::CW-1:0] residualInputOneIm,
	input  wire logic signed [rdt_pkg::CW-1:0] residualInputTwoRe,
	input  wire logic signed [rdt_pkg::CW-1:0] residualInputTwoIm,
	input  wire logic [2:0]                activeGroup,
	input  wire logic                      blockIn,
	output logic                           tripOut,
	output logic                           blockedOut,
	output logic                           pickupOut,
	output logic      [1:0]                condition,
	output logic                           blockEvent,
	output logic                           displayEvent,
	output logic      [rdt_pkg::SW-1:0]    eventDiff,
	output logic      [rdt_pkg::SW-1:0]    eventBias,
	output logic      [1:0]                eventFault
);
	localparam int SW = rdt_pkg::SW;

	// ==========================================
	// register state
	logic [5:0]             ctrl_q, ctrl_d;
	logic [rdt_pkg::GW-1:0] set_q [rdt_pkg::NGRP][rdt_pkg::NFLD];
	logic [rdt_pkg::GW-1:0] set_d [rdt_pkg::NGRP][rdt_pkg::NFLD];
	logic [31:0]            rdata_q, rdata_d;
	logic                   ready_q, ready_d;
	logic                   err_q, err_d;
	logic                   compCmd;
	logic                   wrDone;
	logic [2:0]             grpSel;
	logic [2:0]             fldSel;
	logic                   grpHit;

	// ==========================================
	// datapath state
	logic signed [SW-1:0] inRe_q [5];
	logic signed [SW-1:0] inIm_q [5];
	logic signed [SW-1:0] inRe_d [5];
	logic signed [SW-1:0] inIm_d [5];
	logic signed [SW-1:0] compRe_q, compRe_d;
	logic signed [SW-1:0] compIm_q, compIm_d;
	logic                 blk_q, blk_d;
	logic [1:0]           step_q, step_d;
	logic [SW-1:0]        diffMag_q, diffMag_d;
	logic [SW-1:0]        bias_q, bias_d;
	logic signed [SW-1:0] vecRe [6];
	logic signed [SW-1:0] vecIm [6];
	logic [SW-1:0]        mag [6];
	logic [rdt_pkg::TW-1:0] thr;
	logic                 pickup;

	// ==========================================
	// output state
	rdt_pkg::rdt_cond_t cond_q, cond_d;
	logic            pick_q, pick_d;
	logic            trip_q, trip_d;
	logic            blkd_q, blkd_d;
	logic            evt_q, evt_d;
	logic [SW-1:0]   evDiff_q, evDiff_d;
	logic [SW-1:0]   evBias_q, evBias_d;
	logic [1:0]      evFault_q, evFault_d;
	logic [15:0]     blkCnt_q, blkCnt_d;

	// ==========================================
	// APB slave, one wait-free access phase
	always_comb
	begin
		grpHit  = paddr >= rdt_pkg::ADDR_GRP && paddr < rdt_pkg::ADDR_GRPEND;
		grpSel  = paddr[7:5];
		fldSel  = paddr[4:2];
		wrDone  = psel && penable && ready_q && pwrite && !err_q;
		ctrl_d  = ctrl_q;
		set_d   = set_q;
		compCmd = 1'b0;
		ready_d = psel && !penable;
		err_d   = 1'b0;
		rdata_d = 32'h00000000;
		if (psel && !penable)
		begin
			unique case (paddr)
				rdt_pkg::ADDR_CTRL:   rdata_d = {26'h0000000, ctrl_q};
				rdt_pkg::ADDR_STATUS: rdata_d = {28'h0000000, pick_q, blk_q, cond_q};
				rdt_pkg::ADDR_DIFF:   rdata_d = {10'h000, diffMag_q};
				rdt_pkg::ADDR_BIAS:   rdata_d = {10'h000, bias_q};
				rdt_pkg::ADDR_BLKCNT: rdata_d = {16'h0000, blkCnt_q};
				default:
				begin
					// unmapped words and unaligned group slots answer with an error
					if (grpHit && fldSel < 3'h5 && paddr[1:0] == 2'h0)
						rdata_d = {16'h0000, set_q[grpSel][fldSel]};
					else
						err_d = 1'b1;
				end
			endcase
		end
		if (wrDone && paddr == rdt_pkg::ADDR_CTRL)
		begin
			ctrl_d  = pwdata[5:0];
			compCmd = pwdata[rdt_pkg::CB_COMP];
		end
		if (wrDone && grpHit)
			set_d[grpSel][fldSel] = pwdata[15:0];
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_q  <= rdt_pkg::RST_CTRL;
			rdata_q <= 32'h00000000;
			ready_q <= 1'b0;
			err_q   <= 1'b0;
			for (int g = 0; g < rdt_pkg::NGRP; g++)
			begin
				set_q[g][rdt_pkg::F_PICK] <= rdt_pkg::RST_PICK;
				set_q[g][rdt_pkg::F_TP1]  <= rdt_pkg::RST_TP1;
				set_q[g][rdt_pkg::F_TP2]  <= rdt_pkg::RST_TP2;
				set_q[g][rdt_pkg::F_SL1]  <= rdt_pkg::RST_SL1;
				set_q[g][rdt_pkg::F_SL2]  <= rdt_pkg::RST_SL2;
			end
		end
		else if (ce)
		begin
			ctrl_q  <= ctrl_d;
			set_q   <= set_d;
			rdata_q <= rdata_d;
			ready_q <= ready_d;
			err_q   <= err_d;
		end
	end

	// ==========================================
	// magnitudes, one estimator per vector
	genvar k;
	generate
		for (k = 0; k < 6; k++)
		begin : gMag
			rdt_mag uMag (
				.re  (vecRe[k]),
				.im  (vecIm[k]),
				.mag (mag[k])
			);
		end
	endgenerate

	// settings of the group selected now
	rdt_curve uCurve (
		.bias (bias_q),
		.pick (set_q[activeGroup][rdt_pkg::F_PICK]),
		.tp1  (set_q[activeGroup][rdt_pkg::F_TP1]),
		.tp2  (set_q[activeGroup][rdt_pkg::F_TP2]),
		.sl1  (set_q[activeGroup][rdt_pkg::F_SL1]),
		.sl2  (set_q[activeGroup][rdt_pkg::F_SL2]),
		.thr  (thr)
	);

	// ==========================================
	// datapath: capture, magnitude, compare
	always_comb
	begin
		inRe_d   = inRe_q;
		inIm_d   = inIm_q;
		compRe_d = compRe_q;
		compIm_d = compIm_q;
		blk_d    = blk_q;
		step_d   = {step_q[0], 1'b0};
		for (int i = 0; i < 3; i++)
		begin
			vecRe[i] = inRe_q[i];
			vecIm[i] = inIm_q[i];
		end
		vecRe[3] = ctrl_q[rdt_pkg::CB_INSEL] ? inRe_q[4] : inRe_q[3];
		vecIm[3] = ctrl_q[rdt_pkg::CB_INSEL] ? inIm_q[4] : inIm_q[3];
		vecRe[4] = inRe_q[0] + inRe_q[1] + inRe_q[2];
		vecIm[4] = inIm_q[0] + inIm_q[1] + inIm_q[2];
		if (compCmd && ctrl_q[rdt_pkg::CB_CED])
		begin
			compRe_d = vecRe[4];
			compIm_d = vecIm[4];
		end
		if (ctrl_q[rdt_pkg::CB_CED])
		begin
			vecRe[4] = vecRe[4] - compRe_q;
			vecIm[4] = vecIm[4] - compIm_q;
		end
		vecRe[5] = ctrl_q[rdt_pkg::CB_DIR] ? vecRe[4] - vecRe[3] : vecRe[4] + vecRe[3];
		vecIm[5] = ctrl_q[rdt_pkg::CB_DIR] ? vecIm[4] - vecIm[3] : vecIm[4] + vecIm[3];
		// new phasors on each time base strobe
		if (sampleValid)
		begin
			inRe_d[0] = SW'(phaseOneCurrentRe);
			inIm_d[0] = SW'(phaseOneCurrentIm);
			inRe_d[1] = SW'(phaseTwoCurrentRe);
			inIm_d[1] = SW'(phaseTwoCurrentIm);
			inRe_d[2] = SW'(phaseThreeCurrentRe);
			inIm_d[2] = SW'(phaseThreeCurrentIm);
			inRe_d[3] = SW'(residualInputOneRe);
			inIm_d[3] = SW'(residualInputOneIm);
			inRe_d[4] = SW'(residualInputTwoRe);
			inIm_d[4] = SW'(residualInputTwoIm);
			blk_d     = blockIn || (ctrl_q[rdt_pkg::CB_FORCE] && ctrl_q[rdt_pkg::CB_TBLK]);
			step_d    = 2'h1;
		end
		diffMag_d = step_q[0] ? mag[5] : diffMag_q;
		bias_d = bias_q;
		if (step_q[0])
		begin
			if (ctrl_q[rdt_pkg::CB_BIAS])
			begin
				bias_d = mag[0];
				for (int i = 1; i < 4; i++)
					if (mag[i] > bias_d)
						bias_d = mag[i];
			end
			else
				bias_d = SW'(({1'b0, mag[4]} + {1'b0, mag[3]}) >> 1);
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < 5; i++)
			begin
				inRe_q[i] <= '0;
				inIm_q[i] <= '0;
			end
			compRe_q  <= '0;
			compIm_q  <= '0;
			blk_q     <= 1'b0;
			step_q    <= 2'h0;
			diffMag_q <= '0;
			bias_q    <= '0;
		end
		else if (ce)
		begin
			inRe_q    <= inRe_d;
			inIm_q    <= inIm_d;
			compRe_q  <= compRe_d;
			compIm_q  <= compIm_d;
			blk_q     <= blk_d;
			step_q    <= step_d;
			diffMag_q <= diffMag_d;
			bias_q    <= bias_d;
		end
	end

	// ==========================================
	// decision and events
	always_comb
	begin
		// diff above threshold at present bias
		pickup    = rdt_pkg::TW'(diffMag_q) * rdt_pkg::PCT_SCALE > thr;
		cond_d    = cond_q;
		pick_d    = pick_q;
		evt_d     = 1'b0;
		evDiff_d  = evDiff_q;
		evBias_d  = evBias_q;
		evFault_d = evFault_q;
		blkCnt_d  = blkCnt_q;
		if (step_q[1])
		begin
			pick_d = pickup;
			if (!pickup)
				cond_d = rdt_pkg::CondNormal;
			else if (blk_q)
				cond_d = rdt_pkg::CondBlocked;
			else
				cond_d = rdt_pkg::CondTrip;
			if (cond_d == rdt_pkg::CondBlocked && cond_q != rdt_pkg::CondBlocked)
			begin
				evt_d     = 1'b1;
				evDiff_d  = diffMag_q;
				evBias_d  = bias_q;
				evFault_d = {ctrl_q[rdt_pkg::CB_CED], ctrl_q[rdt_pkg::CB_INSEL]};
				blkCnt_d  = blkCnt_q + 16'h0001;
			end
		end
		// decoded ahead so the pins leave a flop
		trip_d = cond_d == rdt_pkg::CondTrip;
		blkd_d = cond_d == rdt_pkg::CondBlocked;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cond_q    <= rdt_pkg::CondNormal;
			pick_q    <= 1'b0;
			trip_q    <= 1'b0;
			blkd_q    <= 1'b0;
			evt_q     <= 1'b0;
			evDiff_q  <= '0;
			evBias_q  <= '0;
			evFault_q <= 2'h0;
			blkCnt_q  <= 16'h0000;
		end
		else if (ce)
		begin
			cond_q    <= cond_d;
			pick_q    <= pick_d;
			trip_q    <= trip_d;
			blkd_q    <= blkd_d;
			evt_q     <= evt_d;
			evDiff_q  <= evDiff_d;
			evBias_q  <= evBias_d;
			evFault_q <= evFault_d;
			blkCnt_q  <= blkCnt_d;
		end
	end

	// ==========================================
	// outputs, all straight from flops
	// condition encoding
	assign condition    = cond_q;
	assign tripOut      = trip_q;
	assign blockedOut   = blkd_q;
	assign pickupOut    = pick_q;
	assign blockEvent   = evt_q;
	assign displayEvent = evt_q;
	assign eventDiff    = evDiff_q;
	assign eventBias    = evBias_q;
	assign eventFault   = evFault_q;
	assign prdata       = rdata_q;
	assign pready       = ready_q;
	assign pslverr      = err_q;

endmodule : rdt_trip

/* File: tb/rdt_trip_checker.sv */
// assertion checker for the residual differential trip logic
`timescale 1ns/1ps
module rdt_trip_checker (
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic       ce,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       sampleValid,
	input wire logic       tripOut,
	input wire logic       blockedOut,
	input wire logic       pickupOut,
	input wire logic [1:0] condition,
	input wire logic       blockEvent,
	input wire logic       displayEvent
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// ==========================================
	// properties
	property p_cond_code; tripOut == (condition == 2'h1) && blockedOut == (condition == 2'h2); endproperty
	property p_trip_pick; tripOut |-> pickupOut && !blockedOut; endproperty
	property p_block_pick; blockedOut |-> pickupOut; endproperty
	// decisions only follow a strobe, three edges on
	property p_late; $changed(condition) |-> $past(sampleValid, 3); endproperty
	property p_blk_event; blockEvent == $rose(blockedOut); endproperty
	property p_disp_event; displayEvent == blockEvent; endproperty
	property p_ready_setup; psel && !penable && ce ##1 ce |-> pready; endproperty
	property p_ready_pulse; pready && ce |=> !pready; endproperty
	property p_err_ready; pslverr |-> pready; endproperty

	// ==========================================
	// assertions
	a_cond_code: assert property (p_cond_code) else $error("outputs disagree with condition");
	a_trip_pick: assert property (p_trip_pick) else $error("trip without pick-up");
	a_block_pick: assert property (p_block_pick) else $error("blocked without pick-up");
	a_late: assert property (p_late) else $error("condition moved without strobe");
	a_blk_event: assert property (p_blk_event) else $error("block event not on entry");
	a_disp_event: assert property (p_disp_event) else $error("display event differs");
	a_ready_setup: assert property (p_ready_setup) else $error("no ready after setup");
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	c_trip: cover property ($rose(tripOut));
	c_block: cover property ($rose(blockedOut));
	c_err: cover property (pslverr);
endmodule : rdt_trip_checker

bind rdt_trip rdt_trip_checker chk (.clk, .nrst, .ce, .psel, .penable, .pready, .pslverr, .sampleValid,
	.tripOut, .blockedOut, .pickupOut, .condition, .blockEvent, .displayEvent);

/* File: tb/rdt_meas_model.sv */
// measurement and blocking source model
`timescale 1ns/1ps
module rdt_meas_model (
	input  wire logic                     clk,
	output logic                          sampleValid,
	output logic signed [rdt_pkg::CW-1:0] cur [10],
	output logic                          blockIn
);
	localparam int W = rdt_pkg::CW;

	initial
	begin
		sampleValid = 1'b0;
		blockIn = 1'b0;
		foreach (cur[i]) cur[i] = '0;
	end

	// ==========================================
	// one phasor set per tick, imaginary parts zero
	// blocking given with the set
	task automatic send(input int a, input int b, input int r1, input int r2, input logic blk);
		@(posedge clk);
		sampleValid <= 1'b1;
		blockIn <= blk;
		cur <= '{W'(a), '0, W'(b), '0, '0, '0, W'(r1), '0, W'(r2), '0};
		@(posedge clk);
		sampleValid <= 1'b0;
		// stale values must never pass for data
		blockIn <= ~blk;
		foreach (cur[i]) cur[i] <= ~cur[i];
		@(posedge clk);
	endtask : send
endmodule : rdt_meas_model

/* File: tb/test_residual_differential_trip_logic.sv */
// self-checking bench for the residual differential trip logic
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin badCount++; $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_residual_differential_trip_logic;
	localparam logic [31:0] DFLT [5] = '{32'h3E8, 32'h64, 32'h12C, 32'h3E8, 32'hFA0};
	logic                          clk;
	logic                          nrst;
	logic                          ce;
	logic [rdt_pkg::SW-1:0]        eventBias;
	logic                          psel;
	logic                          penable;
	logic                          pwrite;
	logic [11:0]                   paddr;
	logic [31:0]                   pwdata;
	logic [31:0]                   prdata;
	logic                          pready;
	logic                          pslverr;
	logic                          sampleValid;
	logic signed [rdt_pkg::CW-1:0] cur [10];
	logic [2:0]                    activeGroup;
	logic                          blockIn;
	logic                          tripOut;
	logic                          blockedOut;
	logic                          pickupOut;
	logic [1:0]                    condition;
	logic [rdt_pkg::SW-1:0]        eventDiff;
	logic [1:0]                    eventFault;
	int                            badCount;
	int                            checks;

	rdt_meas_model meas (.clk(clk), .sampleValid(sampleValid), .cur(cur), .blockIn(blockIn));

	rdt_trip dut (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sampleValid(sampleValid), .phaseOneCurrentRe(cur[0]), .phaseOneCurrentIm(cur[1]),
		.phaseTwoCurrentRe(cur[2]), .phaseTwoCurrentIm(cur[3]), .phaseThreeCurrentRe(cur[4]),
		.phaseThreeCurrentIm(cur[5]), .residualInputOneRe(cur[6]), .residualInputOneIm(cur[7]),
		.residualInputTwoRe(cur[8]), .residualInputTwoIm(cur[9]), .activeGroup(activeGroup),
		.blockIn(blockIn), .tripOut(tripOut), .blockedOut(blockedOut), .pickupOut(pickupOut),
		.condition(condition), .blockEvent(), .displayEvent(), .eventDiff(eventDiff), .eventBias(eventBias),
		.eventFault(eventFault));

	always #2.5 clk = ~clk;

	// ==========================================
	// bus and measurement tasks
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		#1;
		while (pready !== 1'b1 && n < 50)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 50)
			badCount++;
		if (!w && !e) `CHK(prdata, d)
		`CHK(pslverr, e)
		@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : acc

	task automatic wc(input logic [31:0] d);
		acc(1'b1, 12'h000, d, 1'b0);
	endtask : wc

	task automatic ev(input int a, input int b, input int r1, input int r2, input logic blk, input logic [1:0] x);
		meas.send(a, b, r1, r2, blk);
		repeat (2) @(posedge clk);
		#1;
		`CHK(condition, x)
		`CHK(tripOut, x == 2'h1)
		`CHK(blockedOut, x == 2'h2)
		`CHK(pickupOut, x != 2'h0)
	endtask : ev

	task automatic testDone;
		if (badCount == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : testDone

	// ==========================================
	// watchdog, run needs about one microsecond
	initial
	begin
		#50us;
		badCount++;
		testDone;
	end

	initial
	begin
		clk = 1'b0;
		nrst = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		activeGroup = 3'h0;
		badCount = 0;
		checks = 0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		acc(1'b0, 12'h000, 32'h0, 1'b0);
		for (int f = 0; f < 5; f++) acc(1'b0, 12'h1E0 + 12'(4 * f), DFLT[f], 1'b0);
		acc(1'b0, 12'h300, 32'h0, 1'b1);
		acc(1'b1, 12'h114, 32'h0, 1'b1);
		ev(20'h0, 20'h0, 20'h1F4, 20'h0, 1'b0, 2'h0);
		ev(20'h0, 20'h0, 20'h5DC, 20'h0, 1'b0, 2'h1);
		wc(32'h1);
		ev(20'h0, 20'h0, 20'h5DC, 20'h0, 1'b0, 2'h0);
		ev(20'h0, 20'h0, 20'h0, 20'h5DC, 1'b0, 2'h1);
		wc(32'h0);
		ev(20'h5DC, 20'h0, 20'h5DC, 20'h0, 1'b0, 2'h1);
		wc(32'h2);
		ev(20'h5DC, 20'h0, 20'h5DC, 20'h0, 1'b0, 2'h0);
		wc(32'h4);
		ev(20'h4E20, -20'sh4E20, 20'h7D0, 20'h0, 1'b0, 2'h0);
		ev(20'h4E20, -20'sh4E20, 20'h7D1, 20'h0, 1'b0, 2'h1);
		ev(20'h9C40, -20'sh9C40, 20'h1B58, 20'h0, 1'b0, 2'h0);
		ev(20'h9C40, -20'sh9C40, 20'h1B59, 20'h0, 1'b0, 2'h1);
		ev(20'h9C40, -20'sh9C40, 20'h1770, 20'h0, 1'b0, 2'h0);
		wc(32'h0);
		ev(20'h9C40, -20'sh9C40, 20'h1770, 20'h0, 1'b0, 2'h1);
		acc(1'b1, 12'h160, 32'h1F4, 1'b0);
		activeGroup <= 3'h3;
		ev(20'h0, 20'h0, 20'h258, 20'h0, 1'b0, 2'h1);
		activeGroup <= 3'h0;
		ev(20'h0, 20'h0, 20'h258, 20'h0, 1'b0, 2'h0);
		ev(20'h0, 20'h0, 20'h5DC, 20'h0, 1'b0, 2'h1);
		ev(20'h0, 20'h0, 20'h5DC, 20'h0, 1'b1, 2'h2);
		`CHK(eventDiff, 22'h0005DC)
		`CHK(eventFault, 2'h0)
		`CHK(eventBias, 22'h0002EE)
		acc(1'b0, 12'h004, 32'hE, 1'b0);
		acc(1'b0, 12'h008, 32'h5DC, 1'b0);
		acc(1'b0, 12'h00C, 32'h2EE, 1'b0);
		acc(1'b0, 12'h010, 32'h1, 1'b0);
		ev(20'h0, 20'h0, 20'h0, 20'h0, 1'b1, 2'h0);
		wc(32'h20);
		ev(20'h0, 20'h0, 20'h5DC, 20'h0, 1'b0, 2'h1);
		wc(32'h30);
		ev(20'h0, 20'h0, 20'h5DC, 20'h0, 1'b0, 2'h2);
		wc(32'h8);
		ev(20'h5DC, 20'h0, 20'h0, 20'h0, 1'b0, 2'h1);
		wc(32'h48);
		acc(1'b0, 12'h000, 32'h8, 1'b0);
		ev(20'h5DC, 20'h0, 20'h0, 20'h0, 1'b0, 2'h0);
		wc(32'h0);
		ev(20'h5DC, 20'h0, 20'h0, 20'h0, 1'b0, 2'h1);
		// clock enable low: strobe ignored, trip holds
		ce <= 1'b0;
		ev(20'h0, 20'h0, 20'h0, 20'h0, 1'b0, 2'h1);
		ce <= 1'b1;
		testDone;
	end
endmodule : test_residual_differential_trip_logic
